// ===== hw/src_ctrl_defs.svh
// Register map, field positions, reset values and timing counts
//**********************************************************************
// What this block does
//**********************************************************************
// What this block does
// - Read-only status: bits 3..0 reverse-left, reverse-right, forward-left, forward-right on
// - First async rate field: codes 00..02 main, 08/09 secondary, resets to 00
// - Second async rate field at bits 15:11, same codes, resets to 08
// - Two isochronous converters, each with two stereo paths on one domain
// - Each iso upconvert channel runs only while its own enable is set
// - Each iso downconvert channel runs only while its own enable is set
// - Iso path enable is refused when its clock budget is exhausted
// - A refused enable never disturbs paths that are already running
// - Per-mixer status shows which mixers really became enabled
// - Async path enable is refused when its clock budget is exhausted
// - Per-path lock status for the four async paths is kept and driven out to interrupt logic
// - Iso high and low fields at bits 15:11, reset 00, same codes
`ifndef SRC_CTRL_DEFS_SVH
`define SRC_CTRL_DEFS_SVH

`define RATE_MSB 15
`define RATE_LSB 11
`define SEC_DOMAIN_BIT 3
`define RATE_FIRST_RST 5'h00
`define RATE_SECOND_RST 5'h08
`define ISO_RATE_RST 5'h00
`define ISO_UP1_BIT 15
`define ISO_UP2_BIT 14
`define ISO_DN1_BIT 9
`define ISO_DN2_BIT 8

`define IDX_ASYNC_ENA 14'h0EE0
`define IDX_ASYNC_STS 14'h0EE1
`define IDX_RATE_ONE 14'h0EE2
`define IDX_RATE_TWO 14'h0EE3
`define IDX_LOCK_STS 14'h0EE4
`define IDX_REJECT 14'h0EE5
`define IDX_CAPACITY 14'h0EE8
`define IDX_ISO_BASE 14'h0EF0
`define ISO_STRIDE 14'h0003
`define IDX_MIX_STS 14'h0EF8

`define CAP_MAIN_RST 8'h10
`define CAP_SEC_RST 8'h10
`define MIX_REJECT_BIT 15
`define PATH_COUNT 12
`define CLK_MHZ 50
`define LOCK_TIME_US 100
`define LOCK_CYCLES (`LOCK_TIME_US * `CLK_MHZ)

`endif

// ===== hw/src_ctrl_pkg.sv
// Types shared by the converter control block
package src_ctrl_pkg;

  typedef struct packed {
    logic [4:0] first;
    logic [4:0] second;
  } async_rates_t;

  typedef struct packed {
    logic [4:0] high;
    logic [4:0] low;
  } iso_rates_t;

  typedef struct packed {
    logic [1:0] iso2_down;
    logic [1:0] iso2_up;
    logic [1:0] iso1_down;
    logic [1:0] iso1_up;
    logic [3:0] async_on;
  } path_run_t;

endpackage : src_ctrl_pkg

// ===== hw/load_admit.sv
// Clock-budget admission of path and mixer enable requests
`timescale 1ns/1ps
`include "src_ctrl_defs.svh"
module load_admit #(
  parameter int N = 16
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [N-1:0] req_i,
  input wire logic [N-1:0] dom_i,
  input wire logic eval_i,
  input wire logic [7:0] cap_main_i,
  input wire logic [7:0] cap_sec_i,
  output logic [N-1:0] run_o,
  output logic [N-1:0] reject_o
);
  logic [N-1:0] next_run;
  logic [N-1:0] next_reject;
  logic [8:0] used_main;
  logic [8:0] used_sec;

  always_comb
  begin
    used_main = 9'h000;
    used_sec = 9'h000;
    next_run = '0;
    next_reject = '0;
    // Running paths are counted first so they are never bumped
    for (int i = 0; i < N; i++)
    begin
      if (req_i[i] && run_o[i])
      begin
        next_run[i] = 1'b1;
        if (dom_i[i])
          used_sec = used_sec + 9'h001;
        else
          used_main = used_main + 9'h001;
      end
    end
    for (int i = 0; i < N; i++)
    begin
      if (req_i[i] && !run_o[i] && eval_i)
      begin
        if (dom_i[i] ? (used_sec < {1'b0, cap_sec_i}) : (used_main < {1'b0, cap_main_i}))
        begin
          next_run[i] = 1'b1;
          if (dom_i[i])
            used_sec = used_sec + 9'h001;
          else
            used_main = used_main + 9'h001;
        end
        else
          next_reject[i] = 1'b1;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
      run_o <= '0;
    else
      run_o <= next_run;
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
      reject_o <= '0;
    else
      reject_o <= next_reject;
  end

endmodule : load_admit

// ===== hw/path_lock.sv
// Per-path lock timers; relock after enable or rate change
`timescale 1ns/1ps
module path_lock #(
  parameter int N = 4,
  parameter int CYC = 5000
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [N-1:0] run_i,
  input wire logic [N-1:0] restart_i,
  output logic [N-1:0] lock_o
);
  localparam int CW = $clog2(CYC + 1);
  localparam logic [CW-1:0] LAST = CW'(CYC);
  logic [CW-1:0] count [N];

  always_ff @(posedge clk)
  begin
    for (int i = 0; i < N; i++)
    begin
      if (!rstn || !run_i[i] || restart_i[i])
        count[i] <= '0;
      else if (count[i] != LAST)
        count[i] <= count[i] + CW'(1);
    end
  end

  always_ff @(posedge clk)
  begin
    for (int i = 0; i < N; i++)
    begin
      if (!rstn)
        lock_o[i] <= 1'b0;
      else
        lock_o[i] <= run_i[i] && !restart_i[i] && (count[i] == LAST);
    end
  end

endmodule : path_lock

// ===== hw/src_ctrl.sv
// Sample-rate converter control: APB registers, admission, lock
`timescale 1ns/1ps
`include "src_ctrl_defs.svh"
module src_ctrl
  import src_ctrl_pkg::*;
#(
  parameter int MIX_N = 8,
  parameter int LOCK_CYC = `LOCK_CYCLES,
  parameter logic [7:0] CAP_MAIN = `CAP_MAIN_RST,
  parameter logic [7:0] CAP_SEC = `CAP_SEC_RST
) (
  input wire logic CLK_I,
  input wire logic RSTN_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [15:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  input wire logic [MIX_N-1:0] MIX_REQ_I,
  input wire logic [MIX_N-1:0] MIX_DOM_I,
  output logic [MIX_N-1:0] MIX_RUN_O,
  output src_ctrl_pkg::path_run_t PATH_RUN_O,
  output src_ctrl_pkg::async_rates_t ASYNC_RATES_O,
  output src_ctrl_pkg::iso_rates_t ISO1_RATES_O,
  output src_ctrl_pkg::iso_rates_t ISO2_RATES_O,
  output logic [3:0] LOCK_O
);
  import src_ctrl_pkg::*;

  localparam int NP = `PATH_COUNT;
  localparam int NA = NP + MIX_N;

  //**********************************************************************
  // Helpers
  //**********************************************************************
  function automatic logic [4:0] rate_field(input logic [31:0] d);
    rate_field = d[`RATE_MSB:`RATE_LSB];
  endfunction : rate_field

  function automatic logic [31:0] rate_word(input logic [4:0] r);
    rate_word = 32'h0000_0000;
    rate_word[`RATE_MSB:`RATE_LSB] = r;
  endfunction : rate_word

  function automatic logic [13:0] iso_idx(input int n, input int k);
    iso_idx = `IDX_ISO_BASE + 14'(n) * `ISO_STRIDE + 14'(k);
  endfunction : iso_idx

  function automatic logic [3:0] iso_ena_field(input logic [31:0] d);
    iso_ena_field = {d[`ISO_UP1_BIT], d[`ISO_UP2_BIT], d[`ISO_DN1_BIT], d[`ISO_DN2_BIT]};
  endfunction : iso_ena_field

  function automatic logic [31:0] iso_ena_word(input logic [3:0] e);
    iso_ena_word = 32'h0000_0000;
    iso_ena_word[`ISO_UP1_BIT] = e[3];
    iso_ena_word[`ISO_UP2_BIT] = e[2];
    iso_ena_word[`ISO_DN1_BIT] = e[1];
    iso_ena_word[`ISO_DN2_BIT] = e[0];
  endfunction : iso_ena_word

  //**********************************************************************
  // Bus decode
  //**********************************************************************
  logic [13:0] idx;
  logic aligned;
  logic setup;
  logic wr_en;
  logic wr_q;
  logic [31:0] rd_data;
  logic rd_hit;

  assign idx = PADDR_I[15:2];
  assign aligned = (PADDR_I[1:0] == 2'b00);
  assign setup = PSEL_I && !PENABLE_I;
  assign wr_en = PSEL_I && PENABLE_I && PWRITE_I && aligned;
  // Zero wait states; read data is captured in the setup cycle
  assign PREADY_O = 1'b1;

  //**********************************************************************
  // Software registers
  //**********************************************************************
  logic [3:0] async_ena;
  logic [4:0] rate_first;
  logic [4:0] rate_second;
  logic [4:0] iso_high [2];
  logic [4:0] iso_low [2];
  logic [3:0] iso_ena [2];
  logic [7:0] cap_main;
  logic [7:0] cap_sec;
  logic [15:0] reject;
  logic [3:0] rate_chg;

  always_ff @(posedge CLK_I)
  begin
    if (!RSTN_I)
      async_ena <= 4'h0;
    else if (wr_en && idx == `IDX_ASYNC_ENA)
      async_ena <= PWDATA_I[3:0];
  end

  always_ff @(posedge CLK_I)
  begin
    if (!RSTN_I)
    begin
      rate_first <= `RATE_FIRST_RST;
      rate_second <= `RATE_SECOND_RST;
    end
    else if (wr_en)
    begin
      if (idx == `IDX_RATE_ONE)
        rate_first <= rate_field(PWDATA_I);
      if (idx == `IDX_RATE_TWO)
        rate_second <= rate_field(PWDATA_I);
    end
  end

  // A write to either async rate register upsets both directions, so all four async paths relock
  always_ff @(posedge CLK_I)
  begin
    if (!RSTN_I)
      rate_chg <= 4'h0;
    else if (wr_en && (idx == `IDX_RATE_ONE || idx == `IDX_RATE_TWO))
      rate_chg <= 4'hF;
    else
      rate_chg <= 4'h0;
  end

  always_ff @(posedge CLK_I)
  begin
    for (int n = 0; n < 2; n++)
    begin
      if (!RSTN_I)
      begin
        iso_high[n] <= `ISO_RATE_RST;
        iso_low[n] <= `ISO_RATE_RST;
        iso_ena[n] <= 4'h0;
      end
      else if (wr_en)
      begin
        if (idx == iso_idx(n, 0))
          iso_high[n] <= rate_field(PWDATA_I);
        if (idx == iso_idx(n, 1))
          iso_low[n] <= rate_field(PWDATA_I);
        if (idx == iso_idx(n, 2))
          iso_ena[n] <= iso_ena_field(PWDATA_I);
      end
    end
  end

  always_ff @(posedge CLK_I)
  begin
    if (!RSTN_I)
    begin
      cap_main <= CAP_MAIN;
      cap_sec <= CAP_SEC;
    end
    else if (wr_en && idx == `IDX_CAPACITY)
    begin
      cap_main <= PWDATA_I[7:0];
      cap_sec <= PWDATA_I[15:8];
    end
  end

  // Admission is judged the cycle after a write so it sees new fields
  always_ff @(posedge CLK_I)
  begin
    if (!RSTN_I)
      wr_q <= 1'b0;
    else
      wr_q <= wr_en;
  end

  //**********************************************************************
  // Admission of paths and mixers
  //**********************************************************************
  logic [MIX_N-1:0] mix_q;
  logic [NA-1:0] req;
  logic [NA-1:0] dom;
  logic [NA-1:0] run;
  logic [NA-1:0] rej;
  logic eval;

  always_ff @(posedge CLK_I)
  begin
    if (!RSTN_I)
      mix_q <= '0;
    else
      mix_q <= MIX_REQ_I;
  end

  // A rising mixer request is judged at once; a refused one is judged again on any rising request or register write
  assign eval = wr_q || |(MIX_REQ_I & ~mix_q);

  always_comb
  begin
    req = '0;
    dom = '0;
    req[3:0] = async_ena;
    dom[1:0] = {2{rate_first[`SEC_DOMAIN_BIT]}};
    dom[3:2] = {2{rate_second[`SEC_DOMAIN_BIT]}};
    for (int n = 0; n < 2; n++)
    begin
      req[4 + 4 * n +: 2] = iso_ena[n][3:2];
      req[6 + 4 * n +: 2] = iso_ena[n][1:0];
      // The high field names the converter's domain
      dom[4 + 4 * n +: 4] = {4{iso_high[n][`SEC_DOMAIN_BIT]}};
    end
    req[NP +: MIX_N] = MIX_REQ_I;
    dom[NP +: MIX_N] = MIX_DOM_I;
  end

  load_admit #(
    .N(NA)
  ) u_admit (
    .clk(CLK_I),
    .rstn(RSTN_I),
    .req_i(req),
    .dom_i(dom),
    .eval_i(eval),
    .cap_main_i(cap_main),
    .cap_sec_i(cap_sec),
    .run_o(run),
    .reject_o(rej)
  );

  // Sticky refusal record; write one to clear, a new refusal wins
  always_ff @(posedge CLK_I)
  begin
    if (!RSTN_I)
      reject <= 16'h0000;
    else
    begin
      for (int i = 0; i < 16; i++)
      begin
        if (i < NP && rej[i])
          reject[i] <= 1'b1;
        else if (i == `MIX_REJECT_BIT && |rej[NP +: MIX_N])
          reject[i] <= 1'b1;
        else if (wr_en && idx == `IDX_REJECT && PWDATA_I[i])
          reject[i] <= 1'b0;
      end
    end
  end

  //**********************************************************************
  // Lock tracking
  //**********************************************************************
  logic [3:0] lock;

  path_lock #(
    .N(4),
    .CYC(LOCK_CYC)
  ) u_lock (
    .clk(CLK_I),
    .rstn(RSTN_I),
    .run_i(run[3:0]),
    .restart_i(rate_chg),
    .lock_o(lock)
  );

  //**********************************************************************
  // Outputs
  //**********************************************************************
  assign PATH_RUN_O.async_on = run[3:0];
  assign PATH_RUN_O.iso1_up = run[5:4];
  assign PATH_RUN_O.iso1_down = run[7:6];
  assign PATH_RUN_O.iso2_up = run[9:8];
  assign PATH_RUN_O.iso2_down = run[11:10];
  assign MIX_RUN_O = run[NP +: MIX_N];
  assign LOCK_O = lock;
  assign ASYNC_RATES_O.first = rate_first;
  assign ASYNC_RATES_O.second = rate_second;
  assign ISO1_RATES_O.high = iso_high[0];
  assign ISO1_RATES_O.low = iso_low[0];
  assign ISO2_RATES_O.high = iso_high[1];
  assign ISO2_RATES_O.low = iso_low[1];

  //**********************************************************************
  // Read path
  //**********************************************************************
  always_comb
  begin
    rd_data = 32'h0000_0000;
    rd_hit = aligned;
    case (idx)
      `IDX_ASYNC_ENA: rd_data[3:0] = async_ena;
      `IDX_ASYNC_STS: rd_data[3:0] = run[3:0];
      `IDX_RATE_ONE: rd_data = rate_word(rate_first);
      `IDX_RATE_TWO: rd_data = rate_word(rate_second);
      `IDX_LOCK_STS: rd_data[3:0] = lock;
      `IDX_REJECT: rd_data[15:0] = reject;
      `IDX_CAPACITY: rd_data[15:0] = {cap_sec, cap_main};
      `IDX_MIX_STS: rd_data[MIX_N-1:0] = run[NP +: MIX_N];
      default:
      begin
        rd_hit = 1'b0;
        for (int n = 0; n < 2; n++)
        begin
          if (idx == iso_idx(n, 0))
          begin
            rd_data = rate_word(iso_high[n]);
            rd_hit = aligned;
          end
          if (idx == iso_idx(n, 1))
          begin
            rd_data = rate_word(iso_low[n]);
            rd_hit = aligned;
          end
          if (idx == iso_idx(n, 2))
          begin
            rd_data = iso_ena_word(iso_ena[n]);
            rd_hit = aligned;
          end
        end
      end
    endcase
    if (!rd_hit)
      rd_data = 32'h0000_0000;
  end

  // Captured at setup so the zero-wait access phase has stable data
  always_ff @(posedge CLK_I)
  begin
    if (!RSTN_I)
    begin
      PRDATA_O <= 32'h0000_0000;
      PSLVERR_O <= 1'b0;
    end
    else if (setup)
    begin
      PRDATA_O <= PWRITE_I ? 32'h0000_0000 : rd_data;
      // Status registers refuse writes as well as unmapped words
      PSLVERR_O <= !rd_hit || (PWRITE_I && (idx == `IDX_ASYNC_STS ||
        idx == `IDX_LOCK_STS || idx == `IDX_MIX_STS));
    end
  end

endmodule : src_ctrl

// ===== sim/mix_src_model.sv
// Behavioural mixer and source-selector model driving enable requests
`timescale 1ns/1ps
module mix_src_model (
  input wire logic clk_i,
  input wire logic [7:0] want_i,
  input wire logic [7:0] dom_want_i,
  output logic [7:0] req_o,
  output logic [7:0] dom_o
);
  //****************
  // Request lines
  //****************
  // Registered so requests change only after an edge, like a real mixer
  always_ff @(posedge clk_i)
  begin
    req_o <= want_i;
    dom_o <= dom_want_i;
  end
endmodule : mix_src_model

// ===== sim/src_ctrl_props.sv
// Assertion checker for the converter control block
`timescale 1ns/1ps
`include "src_ctrl_defs.svh"
module src_ctrl_props #(
  parameter int MIX_N = 8
) (
  input wire logic CLK_I,
  input wire logic RSTN_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [15:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic [31:0] PRDATA_O,
  input wire logic PSLVERR_O,
  input wire logic [MIX_N-1:0] MIX_REQ_I,
  input wire logic [MIX_N-1:0] MIX_RUN_O,
  input wire src_ctrl_pkg::path_run_t PATH_RUN_O,
  input wire src_ctrl_pkg::async_rates_t ASYNC_RATES_O,
  input wire src_ctrl_pkg::iso_rates_t ISO1_RATES_O,
  input wire logic [3:0] LOCK_O
);
  import src_ctrl_pkg::*;
  //****************
  // Helpers
  //****************
  localparam logic [15:0] A_STS = {`IDX_ASYNC_STS, 2'b00};
  localparam logic [15:0] A_R1 = {`IDX_RATE_ONE, 2'b00};
  localparam logic [15:0] A_R2 = {`IDX_RATE_TWO, 2'b00};
  localparam logic [15:0] A_CAP = {`IDX_CAPACITY, 2'b00};
  localparam logic [15:0] A_EN1 = {`IDX_ISO_BASE + 14'h0002, 2'b00};
  logic wr;
  logic rd;
  logic [15:0] cap;
  logic [5:0] n_run;
  assign wr = PSEL_I & PENABLE_I & PWRITE_I;
  assign rd = PSEL_I & PENABLE_I & ~PWRITE_I;
  assign n_run = 6'($countones(PATH_RUN_O)) + 6'($countones(MIX_RUN_O));
  // Budget shadow; only the sum is checked, per-domain split is unseen here
  always_ff @(posedge CLK_I)
  begin
    if (!RSTN_I)
      cap <= {`CAP_SEC_RST, `CAP_MAIN_RST};
    else if (wr && PADDR_I == A_CAP)
      cap <= PWDATA_I[15:0];
  end
  default clocking dc @(posedge CLK_I);
  endclocking
  default disable iff (!RSTN_I);
  //****************
  // Properties
  //****************
  property p_rst;
    !$past(RSTN_I) |-> ASYNC_RATES_O == 10'h008 && ISO1_RATES_O == 10'h000;
  endproperty
  a_rst: assert property (p_rst) else $error("reset rate codes wrong");
  property p_r1;
    wr && PADDR_I == A_R1 |=> ASYNC_RATES_O.first == $past(PWDATA_I[15:11]);
  endproperty
  a_r1: assert property (p_r1) else $error("first rate not stored");
  property p_r2;
    wr && PADDR_I == A_R2 |=> ASYNC_RATES_O.second == $past(PWDATA_I[15:11]);
  endproperty
  a_r2: assert property (p_r2) else $error("second rate not stored");
  property p_ro;
    wr && PADDR_I == A_STS |-> PSLVERR_O;
  endproperty
  a_ro: assert property (p_ro) else $error("status write not refused");
  property p_sts;
    rd && PADDR_I == A_STS |-> PRDATA_O == {28'h0000000, $past(PATH_RUN_O.async_on)};
  endproperty
  a_sts: assert property (p_sts) else $error("status read mismatch");
  property p_up;
    wr && PADDR_I == A_EN1 && !PWDATA_I[`ISO_UP1_BIT] |-> ##[1:3] !PATH_RUN_O.iso1_up[1];
  endproperty
  a_up: assert property (p_up) else $error("upconvert runs while off");
  property p_dn;
    wr && PADDR_I == A_EN1 && !PWDATA_I[`ISO_DN1_BIT] |-> ##[1:3] !PATH_RUN_O.iso1_down[1];
  endproperty
  a_dn: assert property (p_dn) else $error("downconvert runs while off");
  property p_budget;
    n_run > $past(n_run) |-> n_run <= {1'b0, cap[7:0]} + cap[15:8];
  endproperty
  a_budget: assert property (p_budget) else $error("grant beyond budget");
  property p_mix;
    (MIX_RUN_O & ~($past(MIX_REQ_I) | $past(MIX_REQ_I, 2))) == '0;
  endproperty
  a_mix: assert property (p_mix) else $error("mixer runs unrequested");
  property p_lock;
    wr && PADDR_I == A_R2 |-> ##[1:2] LOCK_O == 4'h0;
  endproperty
  a_lock: assert property (p_lock) else $error("lock kept over rate write");
  c_lock: cover property (LOCK_O != 4'h0);
  c_mix: cover property (MIX_RUN_O != '0);
  c_iso: cover property (PATH_RUN_O.iso2_up != 2'b00);
endmodule : src_ctrl_props

bind src_ctrl src_ctrl_props #(.MIX_N(MIX_N)) u_props (
  .CLK_I(CLK_I), .RSTN_I(RSTN_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
  .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O),
  .PSLVERR_O(PSLVERR_O), .MIX_REQ_I(MIX_REQ_I), .MIX_RUN_O(MIX_RUN_O),
  .PATH_RUN_O(PATH_RUN_O), .ASYNC_RATES_O(ASYNC_RATES_O),
  .ISO1_RATES_O(ISO1_RATES_O), .LOCK_O(LOCK_O)
);

// ===== sim/src_ctrl_tb.sv
// Self-checking bench for the converter control block
`timescale 1ns/1ps
`include "src_ctrl_defs.svh"
module src_ctrl_tb;
  import src_ctrl_pkg::*;
  //****************
  // Signals
  //****************
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h00000000;
  logic [7:0] want = 8'h00;
  logic [7:0] dwant = 8'h00;
  logic [7:0] mreq;
  logic [7:0] mdom;
  logic [7:0] mrun;
  logic [31:0] prdata;
  logic pready;
  logic perr;
  logic [3:0] lock;
  path_run_t run;
  async_rates_t rates;
  iso_rates_t iso1;
  iso_rates_t iso2;
  logic [31:0] q;
  int miscompares = 0;
  int n_checks = 0;

  always #10 clk = ~clk;

  mix_src_model u_mix (.clk_i(clk), .want_i(want), .dom_want_i(dwant), .req_o(mreq),
    .dom_o(mdom));
  src_ctrl #(.LOCK_CYC(8)) dut (.CLK_I(clk), .RSTN_I(rstn), .PSEL_I(psel),
    .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata),
    .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(perr), .MIX_REQ_I(mreq),
    .MIX_DOM_I(mdom), .MIX_RUN_O(mrun), .PATH_RUN_O(run), .ASYNC_RATES_O(rates),
    .ISO1_RATES_O(iso1), .ISO2_RATES_O(iso2), .LOCK_O(lock));
  //****************
  // Bus and check tasks
  //****************
  task automatic apb(input logic w, input logic [13:0] idx, input logic [31:0] d,
    output logic e);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= {idx, 2'b00};
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 16)
    begin
      @(posedge clk);
      n++;
    end
    if (n == 16)
      miscompares++;
    q = prdata;
    e = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb
  task automatic wr(input logic [13:0] idx, input logic [31:0] d);
    logic e;
    apb(1'b1, idx, d, e);
  endtask : wr
  task automatic rd(input logic [13:0] idx);
    logic e;
    apb(1'b0, idx, 32'h00000000, e);
  endtask : rd
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    n_checks++;
    if (g !== x)
    begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, g, x);
    end
  endtask : chk
  // Admission lands one edge after the write; two spare edges
  task automatic settle;
    repeat (3) @(posedge clk);
    #1;
  endtask : settle
  function automatic logic [31:0] rf(input logic [4:0] c);
    return {16'h0000, c, 11'h000};
  endfunction : rf
  //****************
  // Scenarios
  //****************
  task automatic t_regs;
    logic [4:0] codes [5] = '{5'h00, 5'h01, 5'h02, 5'h08, 5'h09};
    logic e;
    rd(`IDX_RATE_TWO);
    chk(q, rf(`RATE_SECOND_RST));
    rd(`IDX_ISO_BASE + 14'h0001);
    chk(q, rf(`ISO_RATE_RST));
    foreach (codes[i])
    begin
      // No source selection is ever active here, so rate writes are safe
      wr(`IDX_RATE_ONE, rf(codes[i]));
      wr(`IDX_RATE_TWO, rf(codes[i]));
      wr(`IDX_ISO_BASE, rf(codes[i]));
      wr(`IDX_ISO_BASE + 14'h0001, rf(codes[i]));
      rd(`IDX_RATE_ONE);
      chk(q, rf(codes[i]));
      rd(`IDX_ISO_BASE);
      chk(q, rf(codes[i]));
      chk(32'(rates), {22'h000000, codes[i], codes[i]});
      chk(32'(iso1), {22'h000000, codes[i], codes[i]});
    end
    wr(`IDX_RATE_ONE, rf(5'h00));
    wr(`IDX_RATE_TWO, rf(5'h08));
    wr(`IDX_ISO_BASE, rf(5'h00));
    wr(`IDX_ISO_BASE + 14'h0001, rf(5'h00));
    apb(1'b1, `IDX_ASYNC_STS, 32'h0000000F, e);
    chk(32'(e), 32'h00000001);
    rd(`IDX_ASYNC_STS);
    chk(q, 32'h00000000);
    apb(1'b0, 14'h0EE6, 32'h00000000, e);
    chk(32'(e) ^ q, 32'h00000001);
    $display("regs test done");
  endtask : t_regs
  task automatic t_async;
    wr(`IDX_CAPACITY, 32'h00001001);
    wr(`IDX_ASYNC_ENA, 32'h0000000F);
    settle();
    chk(32'(run.async_on), 32'h0000000D);
    rd(`IDX_ASYNC_STS);
    chk(q, 32'h0000000D);
    rd(`IDX_REJECT);
    chk(q, 32'h00000002);
    wr(`IDX_CAPACITY, 32'h00000000);
    wr(`IDX_ASYNC_ENA, 32'h0000000F);
    settle();
    chk(32'(run.async_on), 32'h0000000D);
    repeat (12) @(posedge clk);
    rd(`IDX_LOCK_STS);
    chk(q, 32'h0000000D);
    wr(`IDX_RATE_TWO, rf(5'h09));
    repeat (2) @(posedge clk);
    #1;
    chk(32'(lock), 32'h00000000);
    repeat (12) @(posedge clk);
    chk(32'(lock), 32'h0000000D);
    wr(`IDX_ASYNC_ENA, 32'h00000000);
    wr(`IDX_REJECT, 32'h00008FFF);
    settle();
    chk(32'(run.async_on), 32'h00000000);
    $display("async test done");
  endtask : t_async
  task automatic t_iso;
    wr(`IDX_CAPACITY, 32'h00000110);
    // Both iso2 rates on the secondary domain, higher code in the high field
    wr(`IDX_ISO_BASE + 14'h0003, rf(5'h09));
    wr(`IDX_ISO_BASE + 14'h0004, rf(5'h08));
    wr(`IDX_ISO_BASE + 14'h0002, 32'h00008200);
    wr(`IDX_ISO_BASE + 14'h0005, 32'h00004100);
    settle();
    chk(32'(run[11:4]), 32'h0000001A);
    chk(32'(iso2), {22'h000000, 5'h09, 5'h08});
    rd(`IDX_REJECT);
    chk(q, 32'h00000400);
    wr(`IDX_ISO_BASE + 14'h0002, 32'h00000000);
    settle();
    chk(32'(run[11:4]), 32'h00000010);
    wr(`IDX_ISO_BASE + 14'h0005, 32'h00000000);
    wr(`IDX_REJECT, 32'h00008FFF);
    $display("iso test done");
  endtask : t_iso
  task automatic t_mix;
    wr(`IDX_CAPACITY, 32'h00000101);
    dwant <= 8'h04;
    want <= 8'h07;
    repeat (4) @(posedge clk);
    #1;
    chk(32'(mrun), 32'h00000005);
    rd(`IDX_MIX_STS);
    chk(q, 32'h00000005);
    rd(`IDX_REJECT);
    chk(q, 32'h00008000);
    want <= 8'h00;
    settle();
    chk(32'(mrun), 32'h00000000);
    $display("mixer test done");
  endtask : t_mix
  task automatic conclude;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : conclude

  initial
  begin
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    t_regs();
    t_async();
    t_iso();
    t_mix();
    conclude();
  end
  // Run needs well under 1000 cycles; timeout at 3000 cycles
  initial
  begin
    #60000;
    miscompares++;
    conclude();
  end
endmodule : src_ctrl_tb
